// ===== dv/eeprom_host_model.sv
/*
 Host controller model driving select, serial clock and serial input.
 Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module eeprom_host_model (
    input wire logic clk,
    input wire logic so_pin,
    input wire logic so_en,
    output logic cs,
    output logic sclk,
    output logic sin
);
    initial begin
        cs = 1'b0;
        sclk = 1'b0;
        sin = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Clock low and high 6 clk each, MSB first
    task automatic shift(input logic [31:0] v, input int n, output logic [31:0] got);
        got = '0;
        for (int i = n - 1; i >= 0; i--) begin
            sin <= v[i];
            tick(6);
            sclk <= 1'b1;
            tick(6);
            got = {got[30:0], so_pin};
            sclk <= 1'b0;
        end
    endtask
    task automatic cmd(input logic [1:0] op, input logic [8:0] a, input int ab,
            input logic [15:0] d, input int db, output logic [31:0] got,
            output logic dum);
        logic [31:0] g;
        cs <= 1'b1;
        tick(4);
        shift(((32'(op) | 32'h4) << ab) | 32'(a), ab + 3, g);
        dum = g[0];
        got = '0;
        if (db > 0) begin
            shift(32'(d), db, got);
        end
        tick(6);
        cs <= 1'b0;
        tick(8);
    endtask
    task automatic poll(output logic first, output logic en, output int waited);
        cs <= 1'b1;
        tick(6);
        first = so_pin;
        en = so_en;
        waited = 0;
        while (so_en && so_pin !== 1'b1 && waited < 1000) begin
            tick(1);
            waited++;
        end
        cs <= 1'b0;
        tick(8);
    endtask
endmodule

// ===== dv/eeprom_port_monitor.sv
/*
 Checker on the serial EEPROM port pins.
 Assumes a bind from the bench top and the single clock clk.
*/
`timescale 1ns/1ps
module eeprom_port_monitor #(
    parameter int prog_cycles = 600
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_select,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic width_select_pin,
    input wire logic serial_out,
    input wire logic serial_out_en,
    input wire logic program_busy,
    input wire logic write_unlocked
);
    int busy_cnt_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Length of the current busy stretch
    always_ff @(posedge clk) begin
        if (sys_rst || !program_busy) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end
    rst_clear_a: assert property (
        $fell(sys_rst) |-> !write_unlocked && !program_busy && !serial_out_en)
        else $error("outputs not clear after reset");
    lock_gate_a: assert property (
        $rose(program_busy) |-> $past(write_unlocked))
        else $error("job started while locked");
    perm_hold_a: assert property (
        !chip_select [*8] |=> $stable(write_unlocked))
        else $error("permission changed while deselected");
    out_release_a: assert property (
        !chip_select [*5] |=> !serial_out_en)
        else $error("output still driven after deselect");
    quiet_low_a: assert property (
        !serial_out_en |-> !serial_out)
        else $error("output high while released");
    drive_select_a: assert property (
        $rose(serial_out_en) |-> chip_select)
        else $error("output driven without select");
    read_edge_a: assert property (
        serial_out_en && $past(serial_out_en) && $changed(serial_out) && !serial_out
        |-> $past(serial_clock_in, 2) || $past(serial_clock_in, 3))
        else $error("read bit changed without clock rise");
    busy_min_a: assert property (
        $fell(program_busy) |-> busy_cnt_r >= prog_cycles)
        else $error("timed cycle too short");
    busy_max_a: assert property (
        busy_cnt_r <= 5 * (prog_cycles + 8))
        else $error("timed cycle too long");
endmodule

// ===== dv/serial_eeprom_port_tb.sv
/*
 Bench for the serial EEPROM port: host model, pin level and checks.
 Assumes package, FIFO, port, monitor and host model compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module serial_eeprom_port_tb;
    import eeprom_port_pkg::*;
    localparam int PC = 600;
    logic clk, sys_rst, wsel, cs, sclk, sin, so, so_en, busy, unl;
    logic do_last, do_pin, dm, b, e;
    logic [31:0] g;
    int fails, comparisons, w, cyc;
    serial_eeprom_port #(.part_kbits(4), .prog_cycles(PC), .fifo_depth(4)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .chip_select(cs), .serial_clock_in(sclk),
        .serial_in(sin), .width_select_pin(wsel), .serial_out(so),
        .serial_out_en(so_en), .program_busy(busy), .write_unlocked(unl));
    eeprom_host_model host_u (.clk(clk), .so_pin(do_pin), .so_en(so_en),
        .cs(cs), .sclk(sclk), .sin(sin));
    // Released pin shows the inverse of its last level
    always @(posedge clk) begin
        if (so_en) begin
            do_last <= so;
        end
    end
    assign do_pin = so_en ? so : ~do_last;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic job(input logic [1:0] op, input logic [8:0] a,
            input logic [15:0] d, input int db);
        host_u.cmd(op, a, wsel ? 8 : 9, d, db, g, dm);
        `CHK(busy, 1'b1)
        host_u.poll(b, e, w);
        `CHK(e, 1'b1)
        `CHK(b, 1'b0)
        `CHK(w <= PC, 1'b1)
        `CHK(busy, 1'b0)
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] x);
        host_u.cmd(OP_READ, a, wsel ? 8 : 9, 16'h0000, wsel ? 16 : 8, g, dm);
        `CHK(dm, 1'b0)
        `CHK(g[15:0], x)
    endtask
    initial begin
        sys_rst = 1'b1;
        wsel = 1'b0;
        do_last = 1'b0;
        fails = 0;
        comparisons = 0;
        cyc = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        host_u.tick(4);
        `CHK(unl, 1'b0)
        host_u.cmd(OP_WRITE, 9'h005, 9, 16'h00a5, 8, g, dm);
        `CHK(busy, 1'b0)
        host_u.cmd(OP_SPECIAL, 9'h180, 9, 16'h0000, 0, g, dm);
        `CHK(unl, 1'b1)
        job(OP_WRITE, 9'h005, 16'h003c, 8);
        rd(9'h005, 16'h003c);
        job(OP_WRITE, 9'h105, 16'h0077, 8);
        rd(9'h105, 16'h0077);
        job(OP_ERASE, 9'h005, 16'h0000, 0);
        rd(9'h005, 16'h00ff);
        job(OP_SPECIAL, 9'h080, 16'h005a, 8);
        rd(9'h1ff, 16'h005a);
        job(OP_SPECIAL, 9'h100, 16'h0000, 0);
        rd(9'h105, 16'h00ff);
        job(OP_WRITE, 9'h005, 16'h003c, 8);
        // Write cut off inside its data bits; the lock below must not finish it
        host_u.cmd(OP_WRITE, 9'h005, 9, 16'h0009, 4, g, dm);
        `CHK(busy, 1'b0)
        host_u.poll(b, e, w);
        `CHK(e, 1'b0)
        host_u.cmd(OP_SPECIAL, 9'h000, 9, 16'h0000, 0, g, dm);
        `CHK(unl, 1'b0)
        host_u.cmd(OP_WRITE, 9'h005, 9, 16'h0099, 8, g, dm);
        `CHK(busy, 1'b0)
        rd(9'h005, 16'h003c);
        host_u.cmd(OP_SPECIAL, 9'h180, 9, 16'h0000, 0, g, dm);
        wsel <= 1'b1;
        host_u.tick(4);
        job(OP_WRITE, 9'h003, 16'h1234, 16);
        rd(9'h003, 16'h1234);
        wsel <= 1'b0;
        host_u.tick(4);
        rd(9'h006, 16'h0034);
        rd(9'h007, 16'h0012);
        tally_and_finish();
    end
endmodule
bind serial_eeprom_port eeprom_port_monitor #(.prog_cycles(prog_cycles)) mon_u (
    .clk(clk), .sys_rst(sys_rst), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .serial_in(serial_in),
    .width_select_pin(width_select_pin), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .program_busy(program_busy),
    .write_unlocked(write_unlocked));

// ===== src/eeprom_port_pkg.sv
/*
 Constants, types and the job word layout of the three-wire EEPROM port.
 Assumes a single 25 MHz clock; all pin timing is recovered by sampling.
*/
// Summary of operation
// - Width pin high selects 16-bit words, low selects 8-bit words.
// - Start bit is followed by two opcode bits and the address field.
// - Address is 7/6 bits on 1K, 9/8 bits on 2K and 4K.
// - On 2K the top address bit is ignored but still clocked.
// - Opcode 10 shifts the word out, bits changing on rising clock.
// - During the last read address bit the output is a dummy zero.
// - After power-on erase and write are refused until one unlock.
// - Opcode 00 with prefix 11 unlocks programming.
// - Opcode 00 with prefix 00 locks programming against later changes.
// - Opcode 11 erases the addressed word to ones, self-timed.
// - Opcode 01 takes 8 or 16 data bits, then programs automatically.
// - Opcode 00 with prefix 10 erases the whole array to ones.
// - Opcode 00 with prefix 01 programs one data word everywhere.
// - Reads work whether or not programming is unlocked.
// - Each self-timed cycle lasts at most 10 ms.
// - Select low then high while busy: output low, high when done.
// - No busy indication once the cycle has already finished.
// - Output is released when select goes low.
package eeprom_port_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int PROG_TIME_MS = 10;
    localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int PART_KBITS_DEF = 4;
    localparam int BYTES_PER_KBIT = 128;
    localparam int ABITS_1K_X8 = 7;
    localparam int ABITS_BIG_X8 = 9;
    localparam int DBITS_X8 = 8;
    localparam int DBITS_X16 = 16;
    localparam int FIFO_DEPTH = 4;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ----------------------------------------
    // Pin vector positions and reset values
    // ----------------------------------------
    localparam int PIN_CS = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SIN = 2;
    localparam int PIN_WSEL = 3;
    localparam logic UNLOCK_RST = 1'b0;
    localparam logic SO_RST = 1'b0;

    // ----------------------------------------
    // Opcodes and special prefixes
    // ----------------------------------------
    localparam logic [1:0] OP_SPECIAL = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] PRE_LOCK = 2'h0;
    localparam logic [1:0] PRE_FILL = 2'h1;
    localparam logic [1:0] PRE_CLEAR = 2'h2;
    localparam logic [1:0] PRE_UNLOCK = 2'h3;

    typedef enum logic [1:0] {
        JOB_ERASE = 2'h0,
        JOB_WRITE = 2'h1,
        JOB_CLEAR = 2'h2,
        JOB_FILL = 2'h3
    } job_t;

    typedef struct packed {
        job_t job;
        logic wide;
        logic [8:0] addr;
        logic [15:0] data;
    } job_word_t;

    localparam int JOB_W = $bits(job_word_t);

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_OP = 6'h02,
        S_ADDR = 6'h04,
        S_DATA = 6'h08,
        S_READ = 6'h10,
        S_SKIP = 6'h20
    } dec_state_t;

    typedef enum logic [1:0] {
        E_IDLE = 2'h1,
        E_RUN = 2'h2
    } eng_state_t;

endpackage

// ===== src/job_fifo.sv
/*
 Small synchronous FIFO holding queued program jobs.
 Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/1ps
module job_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)(
    input wire logic clk,
    input wire logic sys_rst,
    job_fifo_if.store q
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("job_fifo DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign q.in_ready = (cnt_r != (PW+1)'(DEPTH));
    assign q.out_valid = (cnt_r != '0);
    assign q.out_data = mem[rd_r];
    assign push = q.in_valid & q.in_ready;
    assign pop = q.out_valid & q.out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= q.in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// ===== src/job_fifo_if.sv
/*
 Handshake bundle between the instruction decoder and the job queue.
 Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
interface job_fifo_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;

    modport store (
        input in_data, in_valid, out_ready,
        output in_ready, out_data, out_valid
    );
    modport user (
        output in_data, in_valid, out_ready,
        input in_ready, out_data, out_valid
    );
endinterface

// ===== src/serial_eeprom_port.sv
/*
 Three-wire serial EEPROM device: pin synchroniser, instruction decoder,
 read shifter, job queue, self-timed program engine and storage array.
 Assumes select, serial clock, serial input and width pin are asynchronous
 to clk; serial clock phases last several clk periods.
*/
`timescale 1ns/1ps
module serial_eeprom_port #(
    parameter int part_kbits = eeprom_port_pkg::PART_KBITS_DEF,
    parameter int prog_cycles = eeprom_port_pkg::PROG_CYCLES,
    parameter int fifo_depth = eeprom_port_pkg::FIFO_DEPTH
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_select,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic width_select_pin,
    output logic serial_out,
    output logic serial_out_en,
    output logic program_busy,
    output logic write_unlocked
);
    import eeprom_port_pkg::*;

    localparam int MEM_BYTES = part_kbits * BYTES_PER_KBIT;
    localparam int BAW = $clog2(MEM_BYTES);
    localparam int PCW = $clog2(prog_cycles + 1);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (part_kbits != 1 && part_kbits != 2 && part_kbits != 4) begin : g_chk_part
        $error("part_kbits must be 1, 2 or 4");
    end
    if (prog_cycles <= MEM_BYTES) begin : g_chk_cyc
        $error("prog_cycles must exceed the array size in bytes");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic int addr_len(input logic wide);
        int n;
        n = (part_kbits == 1) ? ABITS_1K_X8 : ABITS_BIG_X8;
        return wide ? n - 1 : n;
    endfunction

    function automatic logic [1:0] prefix(input logic [8:0] a, input int len);
        return {a[len-1], a[len-2]};
    endfunction

    // Byte slot of a word address; high bits beyond the array drop out
    function automatic logic [BAW-1:0] byte_index(input logic [8:0] a, input logic wide);
        logic [9:0] b;
        b = wide ? {a, 1'b0} : {1'b0, a};
        return b[BAW-1:0];
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic sclk_d_r;
    logic cs_d_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b0;
        end else begin
            pin_s1_r <= {width_select_pin, serial_in, serial_clock_in, chip_select};
            pin_s2_r <= pin_s1_r;
            sclk_d_r <= pin_s2_r[PIN_SCLK];
            cs_d_r <= pin_s2_r[PIN_CS];
        end
    end

    logic cs;
    logic sin;
    logic wide;
    logic sclk_rise;
    logic cs_rise;

    assign cs = pin_s2_r[PIN_CS];
    assign sin = pin_s2_r[PIN_SIN];
    assign wide = pin_s2_r[PIN_WSEL];
    assign sclk_rise = pin_s2_r[PIN_SCLK] & ~sclk_d_r;
    assign cs_rise = cs & ~cs_d_r;

    // ----------------------------------------
    // Instruction decoder
    // ----------------------------------------
    dec_state_t state_r;
    logic [4:0] cnt_r;
    logic [1:0] op_r;
    logic [8:0] addr_r;
    logic [15:0] data_r;
    logic [4:0] rcnt_r;
    logic [4:0] alen_m1;
    logic [4:0] dlen_m1;
    logic [8:0] addr_nxt;
    logic [15:0] data_nxt;
    logic [1:0] pre;
    logic step;
    logic addr_done;
    logic data_done;
    logic read_last;

    assign alen_m1 = 5'(addr_len(wide) - 1);
    assign dlen_m1 = wide ? 5'(DBITS_X16 - 1) : 5'(DBITS_X8 - 1);
    assign addr_nxt = {addr_r[7:0], sin};
    assign data_nxt = {data_r[14:0], sin};
    assign pre = prefix(addr_nxt, addr_len(wide));
    assign step = cs & sclk_rise;
    // Every address bit is counted, don't-care ones included
    assign addr_done = step && state_r == S_ADDR && cnt_r == alen_m1;
    assign data_done = step && state_r == S_DATA && cnt_r == dlen_m1;
    assign read_last = step && state_r == S_READ && rcnt_r == dlen_m1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            cnt_r <= 5'h00;
            op_r <= 2'h0;
            addr_r <= 9'h000;
            data_r <= 16'h0000;
        end else if (!cs) begin
            state_r <= S_IDLE;
            cnt_r <= 5'h00;
        end else if (sclk_rise) begin
            unique case (state_r)
                S_IDLE: begin
                    if (sin) begin
                        state_r <= S_OP;
                        cnt_r <= 5'h00;
                    end
                end
                S_OP: begin
                    op_r <= {op_r[0], sin};
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == 5'h01) begin
                        state_r <= S_ADDR;
                        cnt_r <= 5'h00;
                    end
                end
                S_ADDR: begin
                    addr_r <= addr_nxt;
                    cnt_r <= cnt_r + 5'h01;
                    if (addr_done) begin
                        cnt_r <= 5'h00;
                        if (op_r == OP_READ) begin
                            state_r <= S_READ;
                        end else if (op_r == OP_WRITE) begin
                            state_r <= S_DATA;
                        end else if (op_r == OP_SPECIAL && pre == PRE_FILL) begin
                            state_r <= S_DATA;
                        end else begin
                            state_r <= S_SKIP;
                        end
                    end
                end
                S_DATA: begin
                    data_r <= data_nxt;
                    cnt_r <= cnt_r + 5'h01;
                    if (data_done) begin
                        state_r <= S_SKIP;
                    end
                end
                S_READ: begin
                    // Sequential read walks on to the next word
                    if (read_last) begin
                        addr_r <= addr_r + 9'h001;
                    end
                end
                S_SKIP: begin
                    state_r <= S_SKIP;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Write permission latch
    // ----------------------------------------
    logic unlocked_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            unlocked_r <= UNLOCK_RST;
        end else if (addr_done && op_r == OP_SPECIAL) begin
            if (pre == PRE_UNLOCK) begin
                unlocked_r <= 1'b1;
            end else if (pre == PRE_LOCK) begin
                unlocked_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Job queue
    // ----------------------------------------
    job_fifo_if #(.WIDTH(JOB_W)) q ();
    job_word_t push_word;
    job_word_t run_r;
    eng_state_t eng_r;
    logic push_req;

    // Locked instructions never reach the queue; a full queue drops them
    always_comb begin
        push_req = 1'b0;
        if (unlocked_r) begin
            if (addr_done && op_r == OP_ERASE) begin
                push_req = 1'b1;
            end
            if (addr_done && op_r == OP_SPECIAL && pre == PRE_CLEAR) begin
                push_req = 1'b1;
            end
            if (data_done) begin
                push_req = 1'b1;
            end
        end
    end

    always_comb begin
        push_word.wide = wide;
        push_word.addr = addr_done ? addr_nxt : addr_r;
        push_word.data = wide ? data_nxt : {8'h00, data_nxt[7:0]};
        if (data_done) begin
            push_word.job = (op_r == OP_WRITE) ? JOB_WRITE : JOB_FILL;
        end else begin
            push_word.job = (op_r == OP_ERASE) ? JOB_ERASE : JOB_CLEAR;
        end
    end

    assign q.in_valid = push_req;
    assign q.in_data = push_word;
    assign q.out_ready = (eng_r == E_IDLE);

    job_fifo #(.WIDTH(JOB_W), .DEPTH(fifo_depth)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .q(q.store)
    );

    // ----------------------------------------
    // Self-timed program engine
    // ----------------------------------------
    logic [PCW-1:0] pcnt_r;
    logic [BAW:0] wr_idx_r;
    logic [BAW:0] wr_end_r;
    logic [BAW-1:0] base;
    logic whole;
    logic [7:0] wr_byte;
    logic busy_now;
    job_word_t head;

    assign head = q.out_data;
    assign base = byte_index(head.addr, head.wide);
    assign whole = (head.job == JOB_CLEAR) || (head.job == JOB_FILL);
    assign busy_now = (eng_r != E_IDLE) || q.out_valid;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eng_r <= E_IDLE;
            pcnt_r <= '0;
            wr_idx_r <= '0;
            wr_end_r <= '0;
            run_r <= '0;
        end else begin
            unique case (eng_r)
                E_IDLE: begin
                    if (q.out_valid) begin
                        eng_r <= E_RUN;
                        run_r <= head;
                        pcnt_r <= PCW'(prog_cycles - 1);
                        if (whole) begin
                            wr_idx_r <= '0;
                            wr_end_r <= (BAW+1)'(MEM_BYTES);
                        end else begin
                            wr_idx_r <= {1'b0, base};
                            wr_end_r <= {1'b0, base} + (head.wide ? 2'd2 : 2'd1);
                        end
                    end
                end
                E_RUN: begin
                    if (wr_idx_r != wr_end_r) begin
                        wr_idx_r <= wr_idx_r + 1'b1;
                    end
                    pcnt_r <= pcnt_r - 1'b1;
                    if (pcnt_r == '0) begin
                        eng_r <= E_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb begin
        if (run_r.job == JOB_ERASE || run_r.job == JOB_CLEAR) begin
            wr_byte = ERASED_BYTE;
        end else if (run_r.wide && wr_idx_r[0]) begin
            wr_byte = run_r.data[15:8];
        end else begin
            wr_byte = run_r.data[7:0];
        end
    end

    // ----------------------------------------
    // Storage array
    // ----------------------------------------
    logic [7:0] mem [MEM_BYTES];
    logic [8:0] rd_src;
    logic [BAW-1:0] rd_i;
    logic [15:0] rd_word;

    always_ff @(posedge clk) begin
        if (eng_r == E_RUN && wr_idx_r != wr_end_r) begin
            mem[wr_idx_r[BAW-1:0]] <= wr_byte;
        end
    end

    assign rd_src = addr_done ? addr_nxt : addr_r;
    assign rd_i = byte_index(rd_src, wide);
    assign rd_word = wide ? {mem[{rd_i[BAW-1:1], 1'b1}], mem[rd_i]} : {mem[rd_i], 8'h00};

    // ----------------------------------------
    // Read shifter, works regardless of the latch
    // ----------------------------------------
    logic [15:0] rd_sh_r;
    logic reload_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_sh_r <= 16'h0000;
            rcnt_r <= 5'h00;
            reload_r <= 1'b0;
        end else begin
            reload_r <= read_last;
            if (addr_done && op_r == OP_READ) begin
                rd_sh_r <= rd_word;
                rcnt_r <= 5'h00;
            end else if (reload_r) begin
                rd_sh_r <= rd_word;
            end else if (step && state_r == S_READ) begin
                rd_sh_r <= {rd_sh_r[14:0], 1'b0};
                rcnt_r <= read_last ? 5'h00 : rcnt_r + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // Ready/busy poll
    // ----------------------------------------
    logic status_r;

    always_ff @(posedge clk) begin
        if (sys_rst || !cs) begin
            status_r <= 1'b0;
        end else if (cs_rise) begin
            status_r <= busy_now;
        end else if (step && state_r == S_IDLE && sin) begin
            status_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Serial output pin and status outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_out <= SO_RST;
            serial_out_en <= 1'b0;
        end else if (!cs) begin
            serial_out <= SO_RST;
            serial_out_en <= 1'b0;
        end else if (status_r) begin
            serial_out <= ~busy_now;
            serial_out_en <= 1'b1;
        end else if (addr_done && op_r == OP_READ) begin
            serial_out <= 1'b0;
            serial_out_en <= 1'b1;
        end else if (step && state_r == S_READ) begin
            serial_out <= rd_sh_r[15];
            serial_out_en <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            program_busy <= 1'b0;
            write_unlocked <= UNLOCK_RST;
        end else begin
            program_busy <= busy_now;
            write_unlocked <= unlocked_r;
        end
    end
endmodule
